/* File: verilog/itr_defines.svh */
/*
 * Offsets, bit positions, reset values and timing counts for the
 * init and timing refinement block.
 * Assumes a 200 MHz ref_clk and the plain register port of itr_core.
 */
`ifndef ITR_DEFINES_SVH
`define ITR_DEFINES_SVH

`define ITR_A_CONFIG     4'h0
`define ITR_A_FIRST_SETUP_REGISTER     4'h1
`define ITR_A_STATION    4'h2
`define ITR_A_PROBE      4'h3
`define ITR_A_SUCCESSOR  4'h4
`define ITR_A_COMMAND    4'h5
`define ITR_A_FLAGS      4'h6
`define ITR_A_INTSTAT    4'h7
`define ITR_A_INTMASK    4'h8

`define ITR_B_RESET      0
`define ITR_B_BYPASS     1
`define ITR_B_REFINED    2

`define ITR_CONFIG_RST   8'h00
`define ITR_FIRST_SETUP_REGISTER_RST   8'h00
`define ITR_STATION_RST  8'h00
`define ITR_MASK_RST     4'h0
`define ITR_STATION_SOFT 8'h00

`define ITR_CMD_CLRINT   8'h01
`define ITR_CMD_ENTX     8'h02
`define ITR_CMD_ENRX     8'h03

`define ITR_INIT_PATTERN 8'hD1
`define ITR_RAM_A_PAT    11'h000
`define ITR_RAM_A_ID     11'h001

`define ITR_CLK_NS       5
`define ITR_INIT_MAX_NS  3000
`define ITR_INIT_MAX_CYC (`ITR_INIT_MAX_NS / `ITR_CLK_NS)
`define ITR_CRYSTAL_CLOCK_MHZ     20
`define ITR_CRYSTAL_CLOCK_DIV     (1000 / (`ITR_CRYSTAL_CLOCK_MHZ * `ITR_CLK_NS))
`define ITR_INTDIS_NS    200
`define ITR_INTDIS_CYC   ((`ITR_INTDIS_NS / `ITR_CLK_NS) + 1)
`define ITR_CMDGAP_NS    100
`define ITR_CMDGAP_CYC   ((`ITR_CMDGAP_NS + `ITR_CLK_NS - 1) / `ITR_CLK_NS)
`define ITR_OS_INTDIS    4
`define ITR_OS_CMDGAP    2
`define ITR_OS_SETPULSE  4

`endif

/* File: verilog/itr_pkg.sv */
/*
 * Types shared by the init and timing refinement block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package itr_pkg;
	typedef enum {UP_IDLE, UP_SYNC, UP_WR_ID} itr_upc_e;
	typedef logic [7:0] itr_byte_t;
	typedef logic [10:0] itr_ram_addr_t;
endpackage

/* File: verilog/itr_core.sv */
/*
 * Init sequencing, interrupt lift, command spacing, flag timing and
 * prescale select handling of a token-passing network controller.
 * Assumes a 200 MHz ref_clk; events and ids arrive from same-clock logic,
 * line_idle arrives from a pin.
 */
`include "itr_defines.svh"
module itr_core #(
	parameter int PS_W = 3
)(
	input  wire logic                  ref_clk,
	input  wire logic                  rst_n,
	input  wire logic [3:0]            regAddr,
	input  wire logic [7:0]            regWdata,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic      [7:0]            regRdata,
	input  wire logic                  lineIdle,
	input  wire logic                  txDoneEvt,
	input  wire logic                  rxDoneEvt,
	input  wire logic                  dupIdMatch,
	input  wire logic [7:0]            successorIn,
	output logic                       ramWrEn,
	output itr_pkg::itr_ram_addr_t     ramAddr,
	output itr_pkg::itr_byte_t         ramData,
	output logic      [PS_W-1:0]       rateSelect,
	output logic                       oversampleTick,
	output logic                       probeEffectsClear,
	output logic                       softResetPulse,
	output logic                       enableTxPulse,
	output logic                       enableRxPulse,
	output itr_pkg::itr_byte_t         stationId,
	output itr_pkg::itr_byte_t         probeId,
	output logic                       interruptOutN
);
	logic [7:0]       cfgReg;
	logic [7:0]       setup1Reg;
	logic [3:0]       maskReg;
	logic [3:0]       intStatReg;
	logic [3:0]       intStatNext;
	logic [7:0]       rdMux;
	logic             dupSeenReg;
	logic             lineIdleMeta;
	logic             lineIdleSync;
	logic [PS_W-1:0]  selStage1;
	logic [PS_W-1:0]  selStage2;
	logic [10:0]      osCntReg;
	logic [5:0]       disCntReg;
	logic [5:0]       disCntNext;
	logic [4:0]       guardReg;
	logic [4:0]       guardNext;
	logic [1:0]       flagReg;
	logic [1:0]       flagNext;
	logic [2:0]       pulseCntReg [0:1];
	logic [2:0]       pulseCntNext [0:1];
	itr_pkg::itr_upc_e upState;
	itr_pkg::itr_upc_e upNext;

	wire refined   = cfgReg[`ITR_B_REFINED];
	wire bypass    = cfgReg[`ITR_B_BYPASS];
	wire wrCfg     = regWr && (regAddr == `ITR_A_CONFIG);
	wire wrSetup1  = regWr && (regAddr == `ITR_A_FIRST_SETUP_REGISTER);
	wire wrStation = regWr && (regAddr == `ITR_A_STATION);
	wire wrProbe   = regWr && (regAddr == `ITR_A_PROBE);
	wire wrCmd     = regWr && (regAddr == `ITR_A_COMMAND);
	wire wrMask    = regWr && (regAddr == `ITR_A_INTMASK);
	wire rdSucc    = regRd && (regAddr == `ITR_A_SUCCESSOR);
	wire rdIntStat = regRd && (regAddr == `ITR_A_INTSTAT);

	// soft reset fires on the rising edge of the reset bit, not its level
	wire softRst = (wrStation && (regWdata == `ITR_STATION_SOFT))
		|| (wrCfg && regWdata[`ITR_B_RESET] && !cfgReg[`ITR_B_RESET]);

	// prescaler: oversample period is the 20 MHz base shifted by the select
	wire [10:0] osPeriod = 11'(`ITR_CRYSTAL_CLOCK_DIV) << rateSelect;
	wire        osWrap   = osCntReg >= (osPeriod - 11'h001);
	assign oversampleTick = osWrap;

	// command decode and spacing
	wire isEnTx     = regWdata == `ITR_CMD_ENTX;
	wire isEnRx     = regWdata == `ITR_CMD_ENRX;
	wire prohibitTx = !refined && (pulseCntReg[0] != 3'h0);
	wire prohibitRx = !refined && (pulseCntReg[1] != 3'h0);
	wire cmdBlocked = (guardReg != 5'h00) || (isEnTx && prohibitTx) || (isEnRx && prohibitRx);
	wire cmdAccept  = wrCmd && !cmdBlocked;
	wire cmdRefused = wrCmd && cmdBlocked;
	wire clrIntCmd  = cmdAccept && (regWdata == `ITR_CMD_CLRINT);
	wire enTxAcc    = cmdAccept && isEnTx;
	wire enRxAcc    = cmdAccept && isEnRx;

	// interrupt lift only starts while the pin is actually asserted
	wire disLoad   = (clrIntCmd || rdSucc) && !interruptOutN;
	wire disActive = disCntReg != 6'h00;

	// micro-program counter decode: every non-idle state is the init routine
	wire upInInit = upState != itr_pkg::UP_IDLE;
	wire syncHold = !lineIdleSync && !(bypass && upInInit);
	wire initDone = upState == itr_pkg::UP_WR_ID;

	wire [1:0] evt      = {rxDoneEvt, txDoneEvt};
	wire [1:0] flagClr  = {enRxAcc, enTxAcc};
	wire [1:0] flagRise = flagNext & ~flagReg;

	always_comb begin
		disCntNext = disCntReg;
		if (disLoad) begin
			disCntNext = refined ? 6'(`ITR_INTDIS_CYC) : 6'(`ITR_OS_INTDIS + 1);
		end else if (disActive && (refined || osWrap)) begin
			disCntNext = disCntReg - 6'h01;
		end
	end

	// legacy counts oversample_clock ticks; one extra tick covers the partial first period
	always_comb begin
		guardNext = guardReg;
		if (cmdAccept) begin
			guardNext = refined ? 5'(`ITR_CMDGAP_CYC) : 5'(`ITR_OS_CMDGAP + 1);
		end else if ((guardReg != 5'h00) && (refined || osWrap)) begin
			guardNext = guardReg - 5'h01;
		end
	end

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			flagNext[i] = flagReg[i];
			pulseCntNext[i] = pulseCntReg[i];
			if (flagClr[i]) begin
				flagNext[i] = 1'b0;
			end
			if (evt[i]) begin
				pulseCntNext[i] = 3'(`ITR_OS_SETPULSE);
				if (!refined) begin
					flagNext[i] = 1'b1;
				end
			end else if ((pulseCntReg[i] != 3'h0) && osWrap) begin
				pulseCntNext[i] = pulseCntReg[i] - 3'h1;
				if (refined && (pulseCntReg[i] == 3'h1)) begin
					flagNext[i] = 1'b1;
				end
			end
			if (softRst) begin
				flagNext[i] = 1'b1;
				pulseCntNext[i] = 3'h0;
			end
		end
	end

	// a read clears the sticky bits, but an event in that cycle survives
	always_comb begin
		intStatNext = rdIntStat ? 4'h0 : intStatReg;
		if (clrIntCmd) begin
			intStatNext = intStatNext & 4'hC;
		end
		intStatNext = intStatNext | {cmdRefused, initDone, flagRise};
	end

	always_comb begin
		upNext = upState;
		case (upState)
			itr_pkg::UP_IDLE: upNext = upState;
			itr_pkg::UP_SYNC: begin
				if (!syncHold) begin
					upNext = itr_pkg::UP_WR_ID;
				end
			end
			itr_pkg::UP_WR_ID: upNext = itr_pkg::UP_IDLE;
			default: upNext = itr_pkg::UP_IDLE;
		endcase
		if (softRst) begin
			upNext = itr_pkg::UP_IDLE;
		end else if (wrStation) begin
			upNext = itr_pkg::UP_SYNC;
		end
	end

	always_comb begin
		case (regAddr)
			`ITR_A_CONFIG:    rdMux = cfgReg;
			`ITR_A_FIRST_SETUP_REGISTER:    rdMux = setup1Reg;
			`ITR_A_STATION:   rdMux = stationId;
			`ITR_A_PROBE:     rdMux = probeId;
			`ITR_A_SUCCESSOR: rdMux = successorIn;
			`ITR_A_FLAGS:     rdMux = {4'h0, dupSeenReg, upInInit, flagReg};
			`ITR_A_INTSTAT:   rdMux = {4'h0, intStatReg};
			`ITR_A_INTMASK:   rdMux = {4'h0, maskReg};
			default:          rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lineIdleMeta <= 1'b0;
			lineIdleSync <= 1'b0;
		end else begin
			lineIdleMeta <= lineIdle;
			lineIdleSync <= lineIdleMeta;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgReg <= `ITR_CONFIG_RST;
			setup1Reg <= `ITR_FIRST_SETUP_REGISTER_RST;
			stationId <= `ITR_STATION_RST;
			probeId <= 8'h00;
		end else begin
			if (wrCfg) cfgReg <= regWdata;
			if (wrSetup1) setup1Reg <= regWdata;
			if (wrStation) stationId <= regWdata;
			if (wrProbe) probeId <= regWdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			maskReg <= `ITR_MASK_RST;
		end else if (softRst && refined) begin
			maskReg <= `ITR_MASK_RST;
		end else if (wrMask) begin
			maskReg <= regWdata[3:0];
		end
	end

	// legacy feeds the select straight in and may cut a period short;
	// refined swaps only at a period boundary after two stages
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			selStage1 <= '0;
			selStage2 <= '0;
			rateSelect <= '0;
			osCntReg <= 11'h000;
		end else begin
			selStage1 <= setup1Reg[PS_W-1:0];
			selStage2 <= selStage1;
			if (!refined) begin
				rateSelect <= setup1Reg[PS_W-1:0];
			end else if (osWrap) begin
				rateSelect <= selStage2;
			end
			osCntReg <= osWrap ? 11'h000 : osCntReg + 11'h001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			disCntReg <= 6'h00;
			guardReg <= 5'h00;
			flagReg <= 2'b11;
			pulseCntReg[0] <= 3'h0;
			pulseCntReg[1] <= 3'h0;
			intStatReg <= 4'h0;
			interruptOutN <= 1'b1;
		end else begin
			disCntReg <= disCntNext;
			guardReg <= guardNext;
			flagReg <= flagNext;
			pulseCntReg[0] <= pulseCntNext[0];
			pulseCntReg[1] <= pulseCntNext[1];
			intStatReg <= intStatNext;
			interruptOutN <= !(|(intStatReg & maskReg)) || disActive;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			upState <= itr_pkg::UP_IDLE;
			ramWrEn <= 1'b0;
			ramAddr <= `ITR_RAM_A_PAT;
			ramData <= 8'h00;
		end else begin
			upState <= upNext;
			ramWrEn <= 1'b0;
			if ((upState == itr_pkg::UP_SYNC) && !syncHold && !softRst) begin
				ramWrEn <= 1'b1;
				ramAddr <= `ITR_RAM_A_PAT;
				ramData <= `ITR_INIT_PATTERN;
			end else if (initDone && !softRst) begin
				ramWrEn <= 1'b1;
				ramAddr <= `ITR_RAM_A_ID;
				ramData <= stationId;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dupSeenReg <= 1'b0;
			probeEffectsClear <= 1'b0;
			softResetPulse <= 1'b0;
			enableTxPulse <= 1'b0;
			enableRxPulse <= 1'b0;
			regRdata <= 8'h00;
		end else begin
			probeEffectsClear <= refined && (wrProbe || wrStation);
			dupSeenReg <= dupIdMatch || (dupSeenReg && !(refined && (wrProbe || wrStation)));
			softResetPulse <= softRst;
			enableTxPulse <= enTxAcc;
			enableRxPulse <= enRxAcc;
			regRdata <= regRd ? rdMux : 8'h00;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_station_wr;
		regWr && (regAddr == `ITR_A_STATION) && (regWdata != 8'h00) && bypass;
	endsequence
	sequence s_init_pair;
		ramWrEn && (ramAddr == `ITR_RAM_A_PAT) && (ramData == `ITR_INIT_PATTERN)
		##1 ramWrEn && (ramAddr == `ITR_RAM_A_ID) && (ramData == stationId);
	endsequence

	a_sync_line_wait: assert property (
		(upState == itr_pkg::UP_SYNC) && !bypass && !lineIdleSync && !wrStation |=> !ramWrEn
	) else $error("init write made on a busy line without bypass");
	a_bypass_init_go: assert property (
		(upState == itr_pkg::UP_SYNC) && bypass && !regWr |=> ramWrEn && (ramAddr == `ITR_RAM_A_PAT)
	) else $error("bypass did not release the init write");
	a_init_ram_pair: assert property (
		s_station_wr ##1 !regWr[*2] |-> s_init_pair
	) else $error("init pattern and station id not written in order");
	a_init_in_bound: assert property (
		s_station_wr ##1 !regWr |-> ##[1:3] (ramWrEn && (ramAddr == `ITR_RAM_A_PAT))
	) else $error("bypassed init write late");
	a_intdis_refined: assert property (
		refined && disLoad ##1 !regWr[*3] |-> ##37 interruptOutN
	) else $error("interrupt lift shorter than 200 ns");
	a_intdis_lift: assert property (
		disLoad |-> ##2 interruptOutN
	) else $error("interrupt not lifted after clear or successor read");
	a_cmd_gap_fixed: assert property (
		refined && cmdAccept |-> ##20 (guardReg == 5'h01) ##1 (guardReg == 5'h00)
	) else $error("refined command spacing not 100 ns");
	a_cmd_gap_legacy: assert property (
		!refined && cmdAccept |=> !cmdAccept[*8]
	) else $error("legacy command spacing below one oversample period");
	a_flag_legacy: assert property (
		!refined && txDoneEvt && !softRst |=> flagReg[0] && prohibitTx
	) else $error("legacy flag did not rise with the prohibit window");
	a_flag_refined: assert property (
		refined && txDoneEvt && !flagReg[0] && !softRst |=> !flagReg[0] && !prohibitTx
	) else $error("refined flag rose at pulse start");
	a_probe_clear: assert property (
		refined && (wrProbe || wrStation) && !dupIdMatch |=> probeEffectsClear && !dupSeenReg
	) else $error("stale probe effects not cleared");
	a_mask_soft: assert property (
		softRst && refined |=> (maskReg == 4'h0) && (flagReg == 2'b11) && softResetPulse
	) else $error("soft reset left mask or flags");
	a_soft_station: assert property (
		wrStation && (regWdata == 8'h00) |=> softResetPulse && (upState == itr_pkg::UP_IDLE)
	) else $error("station id 00h did not soft reset");
	a_prescale_sync: assert property (
		$past(refined) && refined && (rateSelect != $past(rateSelect)) |-> $past(osWrap)
	) else $error("prescale select applied mid period");
endmodule

/* File: tb/itr_net_model.sv */
/*
 * Network-side stand-in for the refinement block: line activity pin,
 * frame done events, duplicate_probe_identifier match and a fixed successor id.
 * Assumes the bench raises its requests right after a ref_clk edge.
 */
module itr_net_model #(
	parameter logic [7:0] SUCC = 8'h5c
)(
	input  wire logic       ref_clk,
	input  wire logic       lineBusy,
	input  wire logic       txKick,
	input  wire logic       rxKick,
	output logic            lineIdle,
	output logic            txDoneEvt,
	output logic            rxDoneEvt,
	output logic            dupIdMatch,
	output logic      [7:0] successorIn
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		lineIdle = 1'b1;
		txDoneEvt = 1'b0;
		rxDoneEvt = 1'b0;
		dupIdMatch = 1'b0;
	end
	// the line pin is unrelated to ref_clk, so it moves off the edge
	always @(lineBusy) begin
		lineIdle <= #2 !lineBusy;
	end
	// done events are one-cycle pulses in the design's clock
	always @(posedge ref_clk) begin
		txDoneEvt <= txKick;
		rxDoneEvt <= rxKick;
		dupIdMatch <= txKick & rxKick;
	end
	assign successorIn = SUCC;
endmodule

/* File: tb/testbench.sv */
/*
 * Self-checking bench for itr_core: legacy and refined timing paths.
 * Assumes itr_defines.svh and the network stand-in itr_net_model.
 */
`include "itr_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   ref_clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic             [3:0] regAddr = 4'h0;
	logic             [7:0] regWdata = 8'h00;
	logic                   regWr = 1'b0;
	logic                   regRd = 1'b0;
	logic                   lineBusy = 1'b0;
	logic                   txKick = 1'b0;
	logic                   rxKick = 1'b0;
	logic             [7:0] regRdata, successorIn, rd, id;
	logic                   lineIdle, txDoneEvt, rxDoneEvt, dupIdMatch;
	logic                   ramWrEn, oversampleTick, probeEffectsClear, softResetPulse;
	logic                   enableTxPulse, enableRxPulse, interruptOutN;
	logic             [2:0] rateSelect;
	itr_pkg::itr_ram_addr_t ramAddr;
	itr_pkg::itr_byte_t     ramData, stationId, probeId;
	int                     errCount = 0;
	int                     numChecks = 0;

	always #2.5 ref_clk = ~ref_clk;

	itr_core DUT (.ref_clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .lineIdle,
		.txDoneEvt, .rxDoneEvt, .dupIdMatch, .successorIn, .ramWrEn, .ramAddr, .ramData,
		.rateSelect, .oversampleTick, .probeEffectsClear, .softResetPulse, .enableTxPulse,
		.enableRxPulse, .stationId, .probeId, .interruptOutN);
	itr_net_model NET (.ref_clk, .lineBusy, .txKick, .rxKick, .lineIdle, .txDoneEvt,
		.rxDoneEvt, .dupIdMatch, .successorIn);

	function automatic logic [31:0] lfsrNext(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wrapUp();
		$display("checks %0d errors %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		numChecks++;
		if (seen !== exp) begin
			errCount++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// a wait that used up its bound ends the run
	task automatic guard(input int n, input int bound);
		if (n >= bound) begin
			errCount++;
			$display("[ERR] wait bound reached");
			wrapUp();
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge ref_clk);
		regWr <= 1'b0;
		#1;
	endtask

	task automatic rdr(input logic [3:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge ref_clk);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask

	task automatic kick(input logic t, input logic r);
		@(posedge ref_clk);
		txKick <= t;
		rxKick <= r;
		@(posedge ref_clk);
		txKick <= 1'b0;
		rxKick <= 1'b0;
	endtask

	task automatic ramseq(input logic [7:0] v, input int bound);
		int n;
		n = 0;
		while (ramWrEn !== 1'b1 && n < bound) begin
			cyc(1);
			n++;
		end
		guard(n, bound);
		chk(ramAddr, `ITR_RAM_A_PAT, "pattern address");
		chk(ramData, `ITR_INIT_PATTERN, "pattern data");
		cyc(1);
		chk({ramWrEn, ramAddr}, {1'b1, `ITR_RAM_A_ID}, "id address");
		chk(ramData, v, "id data");
	endtask

	// counts the cycles the pin stays lifted, starting one cycle after the request
	task automatic liftCheck();
		int n;
		chk(interruptOutN, 0, "pin low before lift");
		cyc(1);
		n = 0;
		while (interruptOutN === 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		guard(n, 300);
		chk(n >= 41, 1, "lift width");
	endtask

	initial begin
		logic [31:0] seed;
		int n;
		seed = 32'h3a46_0171;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		#1;
		chk(interruptOutN, 1, "pin after reset");
		rdr(`ITR_A_CONFIG);
		chk(rd, `ITR_CONFIG_RST, "config reset");
		rdr(`ITR_A_FLAGS);
		chk(rd[1:0], 2'b11, "flags reset");
		rdr(4'hf);
		chk(rd, 8'h00, "unmapped read");
		// legacy: init waits for an idle line
		wr(`ITR_A_INTMASK, 8'h0f);
		lineBusy <= 1'b1;
		wr(`ITR_A_STATION, 8'h5a);
		chk(stationId, 8'h5a, "station id register");
		n = 0;
		repeat (700) begin
			cyc(1);
			if (ramWrEn !== 1'b0)
				n++;
		end
		chk(n, 0, "ram write while busy");
		lineBusy <= 1'b0;
		ramseq(8'h5a, 600);
		wr(`ITR_A_STATION, `ITR_STATION_SOFT);
		chk(softResetPulse, 1, "soft reset on zero id");
		rdr(`ITR_A_INTMASK);
		chk(rd, 8'h0f, "mask kept in legacy");
		rdr(`ITR_A_FLAGS);
		chk(rd[1:0], 2'b11, "flags after soft reset");
		// legacy lift counts oversample ticks, still at least 41 cycles at select 0
		rdr(`ITR_A_SUCCESSOR);
		chk(rd, 8'h5c, "legacy successor value");
		liftCheck();
		for (int i = 0; i < 2; i++) begin
			wr(`ITR_A_COMMAND, i ? `ITR_CMD_ENRX : `ITR_CMD_ENTX);
			chk(i ? enableRxPulse : enableTxPulse, 1, "enable accepted");
			cyc(80);
			kick(i == 0, i == 1);
			rdr(`ITR_A_FLAGS);
			chk(rd[i], 1, "legacy flag at pulse start");
			wr(`ITR_A_COMMAND, i ? `ITR_CMD_ENRX : `ITR_CMD_ENTX);
			chk(i ? enableRxPulse : enableTxPulse, 0, "enable during set pulse");
			cyc(120);
		end
		wr(`ITR_A_PROBE, 8'h21);
		chk(probeId, 8'h21, "probe id register");
		chk(probeEffectsClear, 0, "no probe clear in legacy");
		wr(`ITR_A_FIRST_SETUP_REGISTER, 8'h01);
		cyc(1);
		chk(rateSelect, 1, "legacy select direct");
		wr(`ITR_A_FIRST_SETUP_REGISTER, 8'h00);
		// refined timing with bypass, random ids over a random line
		wr(`ITR_A_INTMASK, 8'h00);
		rdr(`ITR_A_INTSTAT);
		wr(`ITR_A_CONFIG, 8'h06);
		for (int i = 0; i < 4; i++) begin
			seed = lfsrNext(seed);
			id = seed[7:0] | 8'h01;
			lineBusy <= seed[8] | (i == 0);
			wr(`ITR_A_STATION, id);
			chk(probeEffectsClear, 1, "station write clears probe");
			ramseq(id, 600);
			cyc(5);
		end
		lineBusy <= 1'b0;
		chk(interruptOutN, 1, "masked status");
		wr(`ITR_A_INTMASK, 8'h04);
		cyc(2);
		wr(`ITR_A_COMMAND, `ITR_CMD_CLRINT);
		liftCheck();
		rdr(`ITR_A_SUCCESSOR);
		chk(rd, 8'h5c, "successor value");
		liftCheck();
		rdr(`ITR_A_INTSTAT);
		chk(rd[2], 1, "init done status");
		rdr(`ITR_A_INTSTAT);
		chk(rd[2], 0, "status cleared by read");
		cyc(2);
		chk(interruptOutN, 1, "pin released");
		wr(`ITR_A_COMMAND, `ITR_CMD_ENTX);
		chk(enableTxPulse, 1, "first command");
		wr(`ITR_A_COMMAND, `ITR_CMD_ENTX);
		chk(enableTxPulse, 0, "command inside spacing");
		cyc(22);
		wr(`ITR_A_COMMAND, `ITR_CMD_ENRX);
		chk(enableRxPulse, 1, "command after spacing");
		cyc(25);
		kick(1'b1, 1'b1);
		rdr(`ITR_A_FLAGS);
		chk({rd[3], rd[1:0]}, 3'b100, "flags wait for pulse end");
		n = 0;
		while (rd[0] !== 1'b1 && n < 100) begin
			rdr(`ITR_A_FLAGS);
			n++;
		end
		guard(n, 100);
		wr(`ITR_A_COMMAND, `ITR_CMD_ENTX);
		chk(enableTxPulse, 1, "enable right after flag");
		wr(`ITR_A_PROBE, 8'h33);
		chk(probeEffectsClear, 1, "probe write clears");
		rdr(`ITR_A_FLAGS);
		chk(rd[3], 0, "duplicate cleared");
		wr(`ITR_A_FIRST_SETUP_REGISTER, 8'h02);
		chk(rateSelect, 0, "select held in sync stages");
		cyc(40);
		chk(rateSelect, 2, "select applied");
		// any 80 consecutive cycles hold exactly two ticks of a 40-cycle period
		n = 0;
		repeat (80) begin
			cyc(1);
			n += oversampleTick;
		end
		chk(n, 80 / (`ITR_CRYSTAL_CLOCK_DIV << 2), "tick count at select 2");
		wr(`ITR_A_FIRST_SETUP_REGISTER, 8'h00);
		cyc(60);
		wr(`ITR_A_INTMASK, 8'h0f);
		wr(`ITR_A_CONFIG, 8'h07);
		chk(softResetPulse, 1, "soft reset on reset bit");
		rdr(`ITR_A_INTMASK);
		chk(rd, 8'h00, "mask cleared in refined");
		rdr(`ITR_A_FLAGS);
		chk(rd[1:0], 2'b11, "flags after refined reset");
		wrapUp();
	end
endmodule
